// file: line_ctrl_defs.svh
// constants for the general-purpose line controller
// assumes inclusion by its bare name from the package file; the design file has no include of its own
`ifndef LINE_CTRL_DEFS_SVH
`define LINE_CTRL_DEFS_SVH

`define LC_NUM_LINES       32
`define LC_PULLUP_RST      32'h0000_0000
`define LC_PERIPH_SEL_RST  32'h0000_0000
`define LC_OUT_EN_RST      32'h0000_0000
`define LC_OUT_DATA_RST    32'h0000_0000
`define LC_WMASK_RST       32'h0000_0000
`define LC_OWN_RST_DEF     32'hFFFF_FFFF
`define LC_MUXED_DEF       32'hFFFF_FFFF

`endif

// file: line_ctrl_pkg.sv
// types shared by the line controller
// assumes line_ctrl_defs.svh is on the include path
`include "line_ctrl_defs.svh"

package line_ctrl_pkg;

   typedef logic [`LC_NUM_LINES-1:0] lines_t;

   // one set/clear write pair; each pulse is one clock wide
   typedef struct packed {
      logic   set_we;
      logic   clr_we;
      lines_t data;
   } setclr_s;

   // drive of one peripheral onto the pins
   typedef struct packed {
      lines_t out_val;
      lines_t out_en;
   } periph_drive_s;

endpackage

// file: line_ctrl.sv
// general-purpose line controller with two-way peripheral multiplexing
// assumes write strobes come from logic on clk; pins and pclk_en come from outside
//
// Summary of operation
// [R1] pull-up enable write clears status bits, disable write sets them
// [R2] pull-up status 1 means pull-up off; drives pin pull-up control
// [R3] pull-up writes act regardless of ownership or direction
// [R4] pull-up status resets to zero, all pull-ups on
// [R5] own enable/disable writes set/clear ownership; 1 is controller, 0 peripheral
// [R6] unmuxed lines ignore ownership writes and always read owned
// [R7] ownership reset value is a per-product parameter
// [R8] select-A write clears, select-B write sets peripheral select bits
// [R9] A/B select steers outputs only; pin input reaches both peripherals
// [R10] peripheral select status resets to zero, peripheral A
// [R11] select writes update status even when controller owns the line
// [R12] peripheral-owned lines take output value and enable from selected peripheral
// [R13] output enable/disable writes set/clear output status; 1 drives
// [R14] set/clear output writes set/clear output data bits
// [R15] output writes update status even while a peripheral owns the line
// [R16] direct output data write changes only write-mask enabled bits
// [R17] write-mask enable/disable set/clear mask; resets to zero
// [R18] register writes work with the peripheral clock gated
// [R19] sampling and change detection run only with peripheral clock on
// [R20] peripheral clock is off after reset until enabled
// [R21] software enables the clock before trusting pin levels
// [R22] handing a pin to a peripheral needs select and disable writes
// [R23] each line keeps the same bit position in every register
// [R24] write-only registers read zero; writes apply in write order

module line_ctrl
   import line_ctrl_pkg::*;
#(
   parameter lines_t OWN_RST = `LC_OWN_RST_DEF,  // product reset ownership
   parameter lines_t MUXED   = `LC_MUXED_DEF     // 1 where a peripheral is muxed
) (
   input  wire logic          clk,            // 100 MHz clock
   input  wire logic          rst_n,          // async reset, active low
   input  wire logic          ce,             // clock enable, freezes all state but the reset release when low
   input  wire logic          pclk_en,        // power-manager clock enable level
   input  wire setclr_s       pullup_wr,      // set=disable reg, clr=enable reg
   input  wire setclr_s       own_wr,         // set=enable reg, clr=disable reg
   input  wire setclr_s       sel_wr,         // set=select-B, clr=select-A
   input  wire setclr_s       out_en_wr,      // set=enable, clr=disable
   input  wire setclr_s       out_data_wr,    // set=set data, clr=clear data
   input  wire setclr_s       wmask_wr,       // set=mask enable, clr=mask disable
   input  wire logic          odata_we,       // direct output data write strobe
   input  wire lines_t        odata_wdata,    // direct output data write value
   input  wire periph_drive_s periph_a,       // peripheral A drive
   input  wire periph_drive_s periph_b,       // peripheral B drive
   input  wire lines_t        pin_in,         // pin levels, asynchronous
   output lines_t             pin_out,        // pin output level
   output lines_t             pin_oe_n,       // pin output enable, low drives
   output lines_t             pullup_off,     // pull-up disable per pin
   output lines_t             periph_in,      // pin input to both peripherals
   output lines_t             pin_level,      // sampled pin levels
   output lines_t             change,         // pin changed since last sample
   output logic               clk_on,         // peripheral clock active
   output lines_t             pullup_status_reg,        // pull-up status
   output lines_t             line_own_status_reg,      // ownership status
   output lines_t             periph_select_status_reg, // A/B select status
   output lines_t             out_status_reg,           // output enable status
   output lines_t             out_data_status_reg,      // output data status
   output lines_t             write_mask_status_reg,    // write mask status
   output lines_t             wr_only_rdata             // read of set/clear regs
);

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic rst_s1_r;
   logic rst_s2_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end

   wire logic srst_n = rst_s2_r;

   // ------------------------------------------------------------
   // set/clear status registers
   // ------------------------------------------------------------
   lines_t pullup_r;
   lines_t own_r;
   lines_t sel_r;
   lines_t oen_r;
   lines_t odata_r;
   lines_t wmask_r;

   // one write per cycle from the bus; set then clear order per cycle
   function automatic lines_t setclr(input lines_t cur, input setclr_s w);
      lines_t v;
      v = cur;
      if (w.set_we) begin
         v = v | w.data;
      end
      if (w.clr_we) begin
         v = v & ~w.data;
      end
      return v;
   endfunction

   // no dependency on pclk_en: writes act with the clock gated
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         pullup_r <= `LC_PULLUP_RST;                        // [R4]
      end else if (ce) begin
         pullup_r <= setclr(pullup_r, pullup_wr);           // [R1] [R3] [R18] [R24]
      end
   end

   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         own_r <= OWN_RST | ~MUXED;                         // [R7] [R6]
      end else if (ce) begin
         own_r <= setclr(own_r, own_wr) | ~MUXED;           // [R5] [R6] [R18]
      end
   end

   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         sel_r <= `LC_PERIPH_SEL_RST;                       // [R10]
      end else if (ce) begin
         sel_r <= setclr(sel_r, sel_wr);                    // [R8] [R11] [R18]
      end
   end

   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         oen_r <= `LC_OUT_EN_RST;
      end else if (ce) begin
         oen_r <= setclr(oen_r, out_en_wr);                 // [R13] [R15] [R18]
      end
   end

   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         odata_r <= `LC_OUT_DATA_RST;
      end else if (ce) begin
         if (odata_we) begin
            odata_r <= (odata_r & ~wmask_r) | (odata_wdata & wmask_r); // [R16]
         end else begin
            odata_r <= setclr(odata_r, out_data_wr);        // [R14] [R15] [R18]
         end
      end
   end

   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         wmask_r <= `LC_WMASK_RST;                          // [R17]
      end else if (ce) begin
         wmask_r <= setclr(wmask_r, wmask_wr);              // [R17]
      end
   end

   // ------------------------------------------------------------
   // peripheral clock gate
   // ------------------------------------------------------------
   logic pclk_s1_r;
   logic pclk_s2_r;

   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         pclk_s1_r <= 1'b0;                                 // [R20]
         pclk_s2_r <= 1'b0;
      end else if (ce) begin
         pclk_s1_r <= pclk_en;
         pclk_s2_r <= pclk_s1_r;
      end
   end

   assign clk_on = pclk_s2_r;

   // ------------------------------------------------------------
   // pin sampling and change detection
   // ------------------------------------------------------------
   lines_t pin_s1_r;
   lines_t pin_s2_r;
   lines_t level_r;
   lines_t change_r;
   logic   primed_r;

   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
      end else if (ce) begin
         pin_s1_r <= pin_in;
         pin_s2_r <= pin_s1_r;
      end
   end

   // level holds while the clock is gated
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         level_r  <= '0;
         change_r <= '0;
         primed_r <= 1'b0;
      end else if (ce) begin
         if (pclk_s2_r) begin
            level_r  <= pin_s2_r;                                   // [R19]
            change_r <= primed_r ? (pin_s2_r ^ level_r) : '0;       // [R19]
            primed_r <= 1'b1;
         end else begin
            change_r <= '0;                                         // [R19]
            primed_r <= 1'b0;
         end
      end
   end

   assign pin_level = level_r;
   assign change    = change_r;
   assign periph_in = pin_s2_r;                             // [R9]

   // ------------------------------------------------------------
   // output multiplexer, one per line
   // ------------------------------------------------------------
   lines_t pin_out_r;
   lines_t pin_oe_n_r;

   generate
      for (genvar i = 0; i < `LC_NUM_LINES; i++) begin : g_line
         logic p_val;
         logic p_en;
         assign p_val = sel_r[i] ? periph_b.out_val[i] : periph_a.out_val[i]; // [R9] [R12]
         assign p_en  = sel_r[i] ? periph_b.out_en[i]  : periph_a.out_en[i];  // [R12]

         always_ff @(posedge clk or negedge srst_n) begin
            if (!srst_n) begin
               pin_out_r[i]  <= 1'b0;
               pin_oe_n_r[i] <= 1'b1;
            end else if (ce) begin
               pin_out_r[i]  <= own_r[i] ? odata_r[i] : p_val;  // [R12] [R23]
               pin_oe_n_r[i] <= own_r[i] ? ~oen_r[i] : ~p_en;   // [R12] [R13]
            end
         end
      end
   endgenerate

   assign pin_out    = pin_out_r;
   assign pin_oe_n   = pin_oe_n_r;
   assign pullup_off = pullup_r;                            // [R2]

   // ------------------------------------------------------------
   // status views
   // ------------------------------------------------------------
   assign pullup_status_reg        = pullup_r;              // [R2]
   assign line_own_status_reg      = own_r;                 // [R6]
   assign periph_select_status_reg = sel_r;
   assign out_status_reg           = oen_r;
   assign out_data_status_reg      = odata_r;
   assign write_mask_status_reg    = wmask_r;
   assign wr_only_rdata            = '0;                    // [R24]

endmodule

// file: periph_model.sv
// two multiplexed peripherals and the pad level seen by the line controller
// assumes the bench supplies the level of released pins
module periph_model
   import line_ctrl_pkg::*;
(
   input  wire lines_t   ext,        // far-side level
   input  wire lines_t   pin_out,    // controller level
   input  wire lines_t   pin_oe_n,   // low drives
   input  wire lines_t   pullup_off, // 1 no pull-up
   output lines_t        pin_in,     // pad level
   output periph_drive_s periph_a,   // peripheral A
   output periph_drive_s periph_b    // peripheral B
);
   timeunit 1ns;
   timeprecision 1ps;
   assign periph_a = '{32'h0F0F_0F0F, 32'hFFFF_FFFF};
   assign periph_b = '{32'h3333_3333, 32'h00FF_00FF};
   // driven, else pulled high, else far side
   assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ~pullup_off) | (pin_oe_n & pullup_off & ext);
endmodule

// file: line_ctrl_sva.sv
// checker for the line controller ports
// assumes a bind onto line_ctrl with MUXED handed on
module line_ctrl_sva
   import line_ctrl_pkg::*;
#(
   parameter lines_t MUXED = 32'hFFFF_FFFF
) (
   input wire logic    clk,                      // clock
   input wire logic    rst_n,                    // reset
   input wire logic    ce,                       // enable
   input wire logic    pclk_en,                  // clock request
   input wire setclr_s pullup_wr,                // pull-up writes
   input wire setclr_s sel_wr,                   // select writes
   input wire setclr_s out_data_wr,              // data writes
   input wire logic    odata_we,                 // direct write
   input wire lines_t  pin_in,                   // pads
   input wire lines_t  pullup_off,               // pull-up off
   input wire lines_t  periph_in,                // to peripherals
   input wire lines_t  change,                   // change pulse
   input wire logic    clk_on,                   // clock active
   input wire lines_t  pullup_status_reg,        // status
   input wire lines_t  line_own_status_reg,      // status
   input wire lines_t  periph_select_status_reg, // status
   input wire lines_t  out_data_status_reg,      // status
   input wire lines_t  write_mask_status_reg,    // status
   input wire lines_t  wr_only_rdata             // zero read
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [2:0] up_r;
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n) up_r <= 3'h0;
      else if (up_r != 3'h7) up_r <= up_r + 3'h1;
   pu_mirror_a: assert property (pullup_off == pullup_status_reg)
      else $error("pull-up control differs from status");
   pu_enable_a: assert property (ce && pullup_wr.clr_we |=>
      (pullup_status_reg & $past(pullup_wr.data)) == 32'h0) else $error("pull-up enable failed");
   pu_disable_a: assert property (ce && pullup_wr.set_we && !pullup_wr.clr_we |=>
      (pullup_status_reg & $past(pullup_wr.data)) == $past(pullup_wr.data)) else $error("pull-up disable failed");
   sel_b_a: assert property (ce && sel_wr.set_we && !sel_wr.clr_we |=>
      (periph_select_status_reg & $past(sel_wr.data)) == $past(sel_wr.data)) else $error("select B failed");
   unmuxed_own_a: assert property ((line_own_status_reg | MUXED) == 32'hFFFF_FFFF)
      else $error("unmuxed line not owned");
   gate_change_a: assert property (!clk_on && !$past(clk_on) && !$past(clk_on, 2) |-> change == 32'h0)
      else $error("change seen with clock off");
   wronly_zero_a: assert property (wr_only_rdata == 32'h0) else $error("write-only read not zero");
   pin_route_a: assert property (up_r == 3'h7 && $past(ce) && $past(ce, 2) |-> periph_in == $past(pin_in, 2))
      else $error("pin input not routed");
   clk_follow_a: assert property (up_r == 3'h7 && $past(ce) && $past(ce, 2) |-> clk_on == $past(pclk_en, 2))
      else $error("clock state wrong");
   mask_hold_a: assert property (ce && odata_we && !out_data_wr.set_we && !out_data_wr.clr_we |=>
      ((out_data_status_reg ^ $past(out_data_status_reg)) & ~$past(write_mask_status_reg)) == 32'h0)
      else $error("masked data bit changed");
   cover property (pullup_wr.set_we);
   cover property (change != 32'h0);
   cover property (odata_we && write_mask_status_reg != 32'h0);
endmodule

bind line_ctrl line_ctrl_sva #(.MUXED(MUXED)) u_sva (.*);

// file: line_ctrl_tb.sv
// self-checking bench for the line controller
// assumes periph_model on the pins and the bound checker
module line_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import line_ctrl_pkg::*;
   logic clk = 0, rst_n = 0, ce = 1, pclk_en = 0, odata_we = 0, clk_on;
   setclr_s pullup_wr = '0, own_wr = '0, sel_wr = '0, out_en_wr = '0, out_data_wr = '0, wmask_wr = '0;
   lines_t odata_wdata = '0, ext = '0, pin_in, pin_out, pin_oe_n, pullup_off, periph_in, pin_level, change;
   lines_t pullup_status_reg, line_own_status_reg, periph_select_status_reg, out_status_reg;
   lines_t out_data_status_reg, write_mask_status_reg, wr_only_rdata;
   periph_drive_s periph_a, periph_b;
   int failures = 0, total_checks = 0, n;
   line_ctrl #(.OWN_RST(32'hFFFF_FFFE), .MUXED(32'h7FFF_FFFF)) uut (.*);
   periph_model pm (.*);
   always #5 clk = ~clk;
   task cyc(input int c);
      repeat (c) @(posedge clk) #1;
   endtask
   task chk(input lines_t got, input lines_t exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task results;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one-cycle write strobe: k picks the pair, s picks set or clear
   task wr(input int k, input bit s, input lines_t d);
      setclr_s v;
      v = '{s, !s, d};
      cyc(1);
      case (k)
         0: pullup_wr = v;
         1: own_wr = v;
         2: sel_wr = v;
         3: out_en_wr = v;
         4: out_data_wr = v;
         default: wmask_wr = v;
      endcase
      cyc(1);
      {pullup_wr, own_wr, sel_wr, out_en_wr, out_data_wr, wmask_wr} = '0;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_reset;
      chk(pullup_status_reg, 32'h0);
      chk(line_own_status_reg, 32'hFFFF_FFFE);
      chk(periph_select_status_reg, 32'h0);
      chk(write_mask_status_reg, 32'h0);
      chk(lines_t'(clk_on), 32'h0);
   endtask
   task t_pullup;
      wr(0, 1, 32'h00F0_00F0);
      chk(pullup_status_reg, 32'h00F0_00F0);
      chk(pullup_off, 32'h00F0_00F0);
      wr(0, 0, 32'h0000_0031);
      chk(pullup_status_reg, 32'h00F0_00C0);
   endtask
   task t_own;
      wr(1, 0, 32'h8000_000E);
      chk(line_own_status_reg, 32'hFFFF_FFF0);
      wr(1, 1, 32'h0000_0002);
      chk(line_own_status_reg, 32'hFFFF_FFF2);
   endtask
   task t_mux;
      wr(2, 1, 32'h0000_001C);
      chk(periph_select_status_reg, 32'h0000_001C);
      cyc(1);
      chk(pin_oe_n & 32'h1F, 32'h12);
      chk(pin_out & 32'hD, 32'h1);
      wr(2, 0, 32'h0000_0010);
      chk(periph_select_status_reg, 32'h0000_000C);
   endtask
   task t_out;
      wr(3, 1, 32'h0000_0003);
      chk(out_status_reg, 32'h0000_0003);
      wr(4, 1, 32'h0000_0003);
      chk(out_data_status_reg, 32'h0000_0003);
      wr(4, 0, 32'h0000_0001);
      chk(out_data_status_reg, 32'h0000_0002);
      cyc(1);
      chk(pin_oe_n & 32'h3, 32'h0);
      chk(pin_out & 32'h3, 32'h3);
   endtask
   task t_mask;
      odata_we = 1;
      odata_wdata = 32'h5555_5555;
      cyc(1);
      odata_we = 0;
      chk(out_data_status_reg, 32'h0000_0002);
      wr(5, 1, 32'h0000_00F0);
      odata_we = 1;
      cyc(1);
      odata_we = 0;
      chk(out_data_status_reg, 32'h0000_0052);
      wr(5, 0, 32'h0000_0030);
      chk(write_mask_status_reg, 32'h0000_00C0);
   endtask
   task t_gate;
      ext = 32'h0000_0080;
      cyc(3);
      chk(periph_in & 32'h80, 32'h80);
      chk(change, 32'h0);
      pclk_en = 1;
      cyc(6);
      chk(lines_t'(clk_on), 32'h1);
      chk(pin_level & 32'h80, 32'h80);
      ext = 32'h0;
      for (n = 0; n < 8 && change[7] !== 1'b1; n++) cyc(1);
      chk(change & 32'h80, 32'h80);
   endtask
   initial begin
      cyc(8);
      rst_n = 1;
      cyc(3);
      t_reset;
      t_pullup;
      t_own;
      t_mux;
      t_out;
      t_mask;
      t_gate;
      results;
   end
endmodule
